// file: lig_pkg.sv
package lig_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [10:0] OFF_DEVICE_IDENTITY = 11'h000;
  localparam logic [10:0] OFF_PATTERN_DETECT_CONTROL = 11'h011;
  localparam logic [10:0] OFF_ARBITRARY_PATTERN_LOW = 11'h012;
  localparam logic [10:0] OFF_ARBITRARY_PATTERN_MID = 11'h013;
  localparam logic [10:0] OFF_ARBITRARY_PATTERN_HIGH = 11'h014;
  localparam logic [10:0] OFF_INBAND_LOOP_CONTROL = 11'h015;
  localparam logic [10:0] OFF_INBAND_GENERATE_CODE = 11'h016;
  localparam logic [10:0] OFF_INBAND_ACTIVATE_CODE = 11'h017;
  localparam logic [10:0] OFF_INBAND_DEACTIVATE_CODE = 11'h018;
  localparam logic [10:0] OFF_LOOPBACK_CONTROL = 11'h019;
  localparam logic [10:0] OFF_INTERRUPT_EDGE_SELECT = 11'h01a;
  localparam logic [10:0] OFF_INTERRUPT_MASK_0 = 11'h01b;
  localparam logic [10:0] OFF_INTERRUPT_MASK_1 = 11'h01c;
  localparam logic [10:0] OFF_INTERRUPT_MASK_2 = 11'h01d;
  localparam logic [10:0] OFF_LINE_STATUS_0 = 11'h01e;
  localparam logic [10:0] OFF_LINE_STATUS_1 = 11'h01f;
  localparam logic [10:0] OFF_INTERRUPT_FLAGS_0 = 11'h020;
  localparam logic [10:0] OFF_INTERRUPT_FLAGS_1 = 11'h021;
  localparam logic [10:0] OFF_INTERRUPT_FLAGS_2 = 11'h022;
  localparam logic [10:0] OFF_ERROR_COUNT_LOW = 11'h023;
  localparam logic [10:0] OFF_ERROR_COUNT_HIGH = 11'h024;
  localparam logic [10:0] OFF_GLOBAL_SOFT_RESET = 11'h040;
  localparam logic [10:0] OFF_EVENT_STATUS = 11'h044;
  localparam logic [10:0] OFF_EVENT_CLEAR = 11'h045;
  localparam logic [10:0] OFF_EVENT_ENABLE = 11'h046;
  localparam logic [10:0] OFF_JITTER_MEAS_CONFIG = 11'h7e5;
  localparam logic [10:0] OFF_JITTER_POS_PEAK_LOW = 11'h7e6;
  localparam logic [10:0] OFF_JITTER_POS_PEAK_HIGH = 11'h7e7;
  localparam logic [10:0] OFF_JITTER_NEG_PEAK_LOW = 11'h7e8;
  localparam logic [10:0] OFF_JITTER_NEG_PEAK_HIGH = 11'h7e9;

  // ----------------------------------------------------------------
  // Values after reset, timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] GLOBAL_SOFT_RESET_RST = 8'h00;
  localparam int SOFT_RESET_MAX_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_MAX_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SOFT_RESET_COUNT = 8'(SOFT_RESET_CYCLES - 1);

  // Event status bit positions
  localparam int EV_SOFT_RESET_DONE = 0;
  localparam int EV_ERR_COUNT_WRAP = 1;
  localparam int EV_JITTER_NEW_PEAK = 2;

  typedef enum logic [0:0] {
    LIG_IDLE,
    LIG_RESETTING
  } lig_state_e;

  // Register port request as one carrier
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lig_req_s;

endpackage : lig_pkg

// file: lig_regs.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Contract
// - A read-only identity byte sits at offset 0x000 and no write or reset changes it.
// - Bits 7:4 of the identity byte return the fixed device code.
// - Bits 3:0 of the identity byte return the revision, zero being the first one.
// - A write to the write-only reset register at 0x040 while no soft reset runs starts a global soft reset; it reads zero.
// - The global soft reset completes within one microsecond.
// - Each error counter is 16 bits, low byte at 0x023 and high byte at 0x024.
// - The 24-bit arbitrary pattern is held in low, middle and high bytes at 0x012 to 0x014.
// - Channel 0 alone has a jitter config byte and 12-bit positive and negative peaks split low/high.
// - Only channel 1 addresses (plus the channel 0 jitter block) are decoded here.
module lig_regs #(
  parameter logic [3:0] DEVICE_CODE = 4'h5, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h0
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [10:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] line_status_0_i,
  input wire logic [7:0] line_status_1_i,
  input wire logic [7:0] int_flags_0_i,
  input wire logic [7:0] int_flags_1_i,
  input wire logic [7:0] int_flags_2_i,
  input wire logic error_inc_i,
  input wire logic jitter_valid_i,
  input wire logic [11:0] jitter_pos_i,
  input wire logic [11:0] jitter_neg_i,
  output logic [23:0] arb_pattern_o,
  output logic [7:0] loopback_control_o,
  output logic [7:0] jitter_meas_config_o,
  output logic soft_reset_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lig_pkg::lig_state_e st;
    logic [7:0] rst_cnt;
    logic [7:0] rdata;
    logic [7:0] pd_ctl;
    logic [23:0] arb;
    logic [7:0] ib_ctl;
    logic [7:0] ib_gen;
    logic [7:0] ib_act;
    logic [7:0] ib_deact;
    logic [7:0] loop_ctl;
    logic [7:0] edge_sel;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [15:0] err_cnt;
    logic [7:0] jm_cfg;
    logic [11:0] jit_pos;
    logic [11:0] jit_neg;
    logic [2:0] ev_stat;
    logic [2:0] ev_en;
  } lig_regs_s;

  lig_regs_s r;
  lig_regs_s next_r;
  lig_pkg::lig_req_s req;
  logic [7:0] identity;
  logic [2:0] ev_set;
  logic [2:0] ev_pending;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign identity = {DEVICE_CODE, REVISION};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    ev_set = 3'b000;
    // Soft reset sequencer: busy for a bounded count, then clears the bank except event enable and event status
    case (r.st)
      lig_pkg::LIG_IDLE: begin
        if (req.wr && req.addr == lig_pkg::OFF_GLOBAL_SOFT_RESET) begin
          next_r.st = lig_pkg::LIG_RESETTING;
          next_r.rst_cnt = lig_pkg::SOFT_RESET_COUNT;
        end
      end
      lig_pkg::LIG_RESETTING: begin
        if (r.rst_cnt == 8'h00) begin
          next_r.st = lig_pkg::LIG_IDLE;
        end else begin
          next_r.rst_cnt = r.rst_cnt - 8'h01;
        end
      end
      default: next_r.st = lig_pkg::LIG_IDLE;
    endcase

    if (r.st == lig_pkg::LIG_IDLE) begin
      // Counter and peak capture run only outside soft reset
      if (error_inc_i) begin
        next_r.err_cnt = r.err_cnt + 16'h0001;
        if (r.err_cnt == 16'hffff) begin
          ev_set[lig_pkg::EV_ERR_COUNT_WRAP] = 1'b1;
        end
      end
      if (jitter_valid_i && !r.jm_cfg[2]) begin
        next_r.jit_pos = jitter_pos_i;
        next_r.jit_neg = jitter_neg_i;
        ev_set[lig_pkg::EV_JITTER_NEW_PEAK] = 1'b1;
      end
      if (req.wr) begin
        case (req.addr)
          lig_pkg::OFF_PATTERN_DETECT_CONTROL: next_r.pd_ctl = {4'h0, req.wdata[3:0]};
          lig_pkg::OFF_ARBITRARY_PATTERN_LOW: next_r.arb[7:0] = req.wdata;
          lig_pkg::OFF_ARBITRARY_PATTERN_MID: next_r.arb[15:8] = req.wdata;
          lig_pkg::OFF_ARBITRARY_PATTERN_HIGH: next_r.arb[23:16] = req.wdata;
          lig_pkg::OFF_INBAND_LOOP_CONTROL: next_r.ib_ctl = {2'b00, req.wdata[5:0]};
          lig_pkg::OFF_INBAND_GENERATE_CODE: next_r.ib_gen = req.wdata;
          lig_pkg::OFF_INBAND_ACTIVATE_CODE: next_r.ib_act = req.wdata;
          lig_pkg::OFF_INBAND_DEACTIVATE_CODE: next_r.ib_deact = req.wdata;
          lig_pkg::OFF_LOOPBACK_CONTROL: next_r.loop_ctl = {4'h0, req.wdata[3:0]};
          lig_pkg::OFF_INTERRUPT_EDGE_SELECT: next_r.edge_sel = {1'b0, req.wdata[6:0]};
          lig_pkg::OFF_INTERRUPT_MASK_0: next_r.mask0 = req.wdata;
          lig_pkg::OFF_INTERRUPT_MASK_1: next_r.mask1 = {req.wdata[7:5], 3'b000, req.wdata[1:0]};
          lig_pkg::OFF_INTERRUPT_MASK_2: next_r.mask2 = {2'b00, req.wdata[5:0]};
          lig_pkg::OFF_JITTER_MEAS_CONFIG: next_r.jm_cfg = {5'h00, req.wdata[2:0]};
          lig_pkg::OFF_EVENT_ENABLE: next_r.ev_en = req.wdata[2:0];
          lig_pkg::OFF_EVENT_CLEAR: next_r.ev_stat = r.ev_stat & ~req.wdata[2:0];
          default: ;
        endcase
      end
    end else if (r.rst_cnt == 8'h00) begin
      // End of soft reset: every register except event enable and event status back to zero
      next_r = '0;
      next_r.ev_en = r.ev_en;
      next_r.ev_stat = r.ev_stat;
      ev_set[lig_pkg::EV_SOFT_RESET_DONE] = 1'b1;
    end

    // Set wins over a clear in the same cycle
    next_r.ev_stat = next_r.ev_stat | ev_set;

    next_r.rdata = lig_pkg::RST_BYTE;
    if (req.rd) begin
      case (req.addr)
        lig_pkg::OFF_DEVICE_IDENTITY: next_r.rdata = identity;
        lig_pkg::OFF_PATTERN_DETECT_CONTROL: next_r.rdata = r.pd_ctl;
        lig_pkg::OFF_ARBITRARY_PATTERN_LOW: next_r.rdata = r.arb[7:0];
        lig_pkg::OFF_ARBITRARY_PATTERN_MID: next_r.rdata = r.arb[15:8];
        lig_pkg::OFF_ARBITRARY_PATTERN_HIGH: next_r.rdata = r.arb[23:16];
        lig_pkg::OFF_INBAND_LOOP_CONTROL: next_r.rdata = r.ib_ctl;
        lig_pkg::OFF_INBAND_GENERATE_CODE: next_r.rdata = r.ib_gen;
        lig_pkg::OFF_INBAND_ACTIVATE_CODE: next_r.rdata = r.ib_act;
        lig_pkg::OFF_INBAND_DEACTIVATE_CODE: next_r.rdata = r.ib_deact;
        lig_pkg::OFF_LOOPBACK_CONTROL: next_r.rdata = r.loop_ctl;
        lig_pkg::OFF_INTERRUPT_EDGE_SELECT: next_r.rdata = r.edge_sel;
        lig_pkg::OFF_INTERRUPT_MASK_0: next_r.rdata = r.mask0;
        lig_pkg::OFF_INTERRUPT_MASK_1: next_r.rdata = r.mask1;
        lig_pkg::OFF_INTERRUPT_MASK_2: next_r.rdata = r.mask2;
        lig_pkg::OFF_LINE_STATUS_0: next_r.rdata = line_status_0_i;
        lig_pkg::OFF_LINE_STATUS_1: next_r.rdata = line_status_1_i;
        lig_pkg::OFF_INTERRUPT_FLAGS_0: next_r.rdata = int_flags_0_i;
        lig_pkg::OFF_INTERRUPT_FLAGS_1: next_r.rdata = int_flags_1_i;
        lig_pkg::OFF_INTERRUPT_FLAGS_2: next_r.rdata = int_flags_2_i;
        lig_pkg::OFF_ERROR_COUNT_LOW: next_r.rdata = r.err_cnt[7:0];
        lig_pkg::OFF_ERROR_COUNT_HIGH: next_r.rdata = r.err_cnt[15:8];
        lig_pkg::OFF_GLOBAL_SOFT_RESET: next_r.rdata = lig_pkg::GLOBAL_SOFT_RESET_RST;
        lig_pkg::OFF_EVENT_STATUS: next_r.rdata = {5'h00, r.ev_stat};
        lig_pkg::OFF_EVENT_ENABLE: next_r.rdata = {5'h00, r.ev_en};
        lig_pkg::OFF_JITTER_MEAS_CONFIG: next_r.rdata = r.jm_cfg;
        lig_pkg::OFF_JITTER_POS_PEAK_LOW: next_r.rdata = r.jit_pos[7:0];
        lig_pkg::OFF_JITTER_POS_PEAK_HIGH: next_r.rdata = {4'h0, r.jit_pos[11:8]};
        lig_pkg::OFF_JITTER_NEG_PEAK_LOW: next_r.rdata = r.jit_neg[7:0];
        lig_pkg::OFF_JITTER_NEG_PEAK_HIGH: next_r.rdata = {4'h0, r.jit_neg[11:8]};
        default: next_r.rdata = lig_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = r.rdata;
  assign arb_pattern_o = r.arb;
  assign loopback_control_o = r.loop_ctl;
  assign jitter_meas_config_o = r.jm_cfg;
  assign soft_reset_o = (r.st == lig_pkg::LIG_RESETTING);

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Per event: pending while enabled, and sticky until software clears it
  for (genvar gi = 0; gi < 3; gi++) begin : g_event
    assign ev_pending[gi] = r.ev_stat[gi] & r.ev_en[gi];

    a_event_sticky: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      r.ev_stat[gi]
      && !(reg_wr_i && reg_addr_i == lig_pkg::OFF_EVENT_CLEAR && reg_wdata_i[gi])
      |=> r.ev_stat[gi])
      else $error("event bit lost");
  end

  assign irq_o = |ev_pending;

  // ----------------------------------------------------------------
  // Checks: identity and soft reset
  // ----------------------------------------------------------------
  a_identity_read: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == lig_pkg::OFF_DEVICE_IDENTITY
    |=> reg_rdata_o == identity)
    else $error("identity read wrong");

  a_identity_code: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h000
    |=> reg_rdata_o[7:4] == DEVICE_CODE)
    else $error("device code wrong");

  a_revision_nibble: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h000
    |=> reg_rdata_o[3:0] == REVISION)
    else $error("revision wrong");

  a_reset_starts: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h040 && !soft_reset_o
    |=> soft_reset_o)
    else $error("soft reset not started");

  a_reset_reg_zero: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h040
    |=> reg_rdata_o == 8'h00)
    else $error("reset register not zero");

  // 250 cycles at 4 ns use up the whole one microsecond budget
  a_reset_bounded: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(soft_reset_o)
    |-> ##[1:250] !soft_reset_o)
    else $error("soft reset too long");

  a_reset_clears: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(soft_reset_o)
    |-> arb_pattern_o == 24'h00_0000 && loopback_control_o == 8'h00)
    else $error("soft reset left state");

  a_reset_clears_count: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(soft_reset_o)
    |-> r.err_cnt == 16'h0000 && r.jit_pos == 12'h000)
    else $error("soft reset left counter");

  a_reset_done_event: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(soft_reset_o)
    |-> r.ev_stat[lig_pkg::EV_SOFT_RESET_DONE])
    else $error("reset done event missing");

  // ----------------------------------------------------------------
  // Checks: data registers
  // ----------------------------------------------------------------
  a_err_low_read: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h023
    |=> reg_rdata_o == $past(r.err_cnt[7:0]))
    else $error("error count low wrong");

  a_err_high_read: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h024
    |=> reg_rdata_o == $past(r.err_cnt[15:8]))
    else $error("error count high wrong");

  a_err_count_step: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    error_inc_i && !soft_reset_o
    |=> r.err_cnt == $past(r.err_cnt) + 16'h0001)
    else $error("error count step wrong");

  a_arb_low_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h012 && !soft_reset_o
    |=> arb_pattern_o[7:0] == $past(reg_wdata_i))
    else $error("pattern low byte wrong");

  a_arb_mid_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h013 && !soft_reset_o
    |=> arb_pattern_o[15:8] == $past(reg_wdata_i))
    else $error("pattern mid byte wrong");

  a_arb_high_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h014 && !soft_reset_o
    |=> arb_pattern_o[23:16] == $past(reg_wdata_i))
    else $error("pattern high byte wrong");

  a_jitter_capture: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    jitter_valid_i && !soft_reset_o && !jitter_meas_config_o[2]
    |=> r.jit_pos == $past(jitter_pos_i) && r.jit_neg == $past(jitter_neg_i))
    else $error("jitter peak not captured");

  a_jitter_frozen: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    jitter_valid_i && !soft_reset_o && jitter_meas_config_o[2]
    |=> $stable(r.jit_pos))
    else $error("jitter peak not frozen");

  a_jitter_high: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h7e7
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("jitter high nibble wrong");

  a_jitter_neg_high: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h7e9
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("jitter negative nibble wrong");

  a_unmapped_zero: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == 11'h7e4
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Idle data is zero, so a stale byte is never taken for an answer
  a_rdata_idle: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !reg_rd_i
    |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");

  // ----------------------------------------------------------------
  // Checks: event registers
  // ----------------------------------------------------------------
  a_event_clear: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h045 && reg_wdata_i[0] && !soft_reset_o
    |=> !r.ev_stat[lig_pkg::EV_SOFT_RESET_DONE])
    else $error("event not cleared");

  a_irq_masked: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == 11'h046 && reg_wdata_i == 8'h00 && !soft_reset_o
    |=> !irq_o)
    else $error("interrupt not masked");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_soft_reset: cover property (@(posedge clk_sys_i) $fell(soft_reset_o));
  c_irq: cover property (@(posedge clk_sys_i) $rose(irq_o));
  c_irq_cleared: cover property (@(posedge clk_sys_i) $fell(irq_o));
  c_err_wrap: cover property (@(posedge clk_sys_i) r.ev_stat[lig_pkg::EV_ERR_COUNT_WRAP]);
  c_peak_frozen: cover property (@(posedge clk_sys_i) jitter_valid_i && jitter_meas_config_o[2]);

endmodule : lig_regs

// file: test_line_interface_global_regs.sv
`timescale 1ns/1ps
module test_line_interface_global_regs;
  // ------------------------------------------
  // Stimulus signals and design instance
  // ------------------------------------------
  localparam logic [3:0] DEV_CODE = 4'ha; // Arbitrary value
  logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, error_inc_i, jitter_valid_i;
  logic [10:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, loopback_control_o, jitter_meas_config_o;
  logic [7:0] line_status_0_i, line_status_1_i, int_flags_0_i, int_flags_1_i, int_flags_2_i;
  logic [11:0] jitter_pos_i, jitter_neg_i;
  logic [23:0] arb_pattern_o;
  logic soft_reset_o, irq_o;
  int errors, n_checks;

  lig_regs #(.DEVICE_CODE(DEV_CODE), .REVISION(4'h0)) dut (.clk_sys_i, .sys_rst_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .line_status_0_i,
    .line_status_1_i, .int_flags_0_i, .int_flags_1_i, .int_flags_2_i, .error_inc_i,
    .jitter_valid_i, .jitter_pos_i, .jitter_neg_i, .arb_pattern_o, .loopback_control_o,
    .jitter_meas_config_o, .soft_reset_o, .irq_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    chk_word(n, {16'h0000, e}, {16'h0000, g});
  endtask : chk_byte

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {23'h0, e}, {23'h0, g});
  endtask : chk_bit

  // Read strobe one cycle, data sampled only in the cycle after it
  task automatic rchk(input logic [10:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_byte(n, e, reg_rdata_o);
  endtask : rchk

  task automatic pulse_jitter(input logic [11:0] p, input logic [11:0] q);
    @(posedge clk_sys_i);
    jitter_pos_i <= p;
    jitter_neg_i <= q;
    jitter_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    jitter_valid_i <= 1'b0;
  endtask : pulse_jitter

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_identity();
    rchk(lig_pkg::OFF_DEVICE_IDENTITY, {DEV_CODE, 4'h0}, "identity");
    wr(lig_pkg::OFF_DEVICE_IDENTITY, 8'hff);
    rchk(lig_pkg::OFF_DEVICE_IDENTITY, {DEV_CODE, 4'h0}, "identity_wr");
    rchk(11'h7e4, 8'h00, "unmapped");
    $display("test identity done");
  endtask : t_identity

  task automatic t_status();
    line_status_0_i <= 8'ha5;
    line_status_1_i <= 8'h5a;
    int_flags_0_i <= 8'h11;
    int_flags_1_i <= 8'h22;
    int_flags_2_i <= 8'h33;
    wr(lig_pkg::OFF_LINE_STATUS_0, 8'hff);
    rchk(lig_pkg::OFF_LINE_STATUS_0, 8'ha5, "status0");
    rchk(lig_pkg::OFF_LINE_STATUS_1, 8'h5a, "status1");
    rchk(lig_pkg::OFF_INTERRUPT_FLAGS_0, 8'h11, "flags0");
    rchk(lig_pkg::OFF_INTERRUPT_FLAGS_1, 8'h22, "flags1");
    rchk(lig_pkg::OFF_INTERRUPT_FLAGS_2, 8'h33, "flags2");
    $display("test status done");
  endtask : t_status

  task automatic t_pattern_counter();
    wr(lig_pkg::OFF_ARBITRARY_PATTERN_LOW, 8'h21);
    wr(lig_pkg::OFF_ARBITRARY_PATTERN_MID, 8'h43);
    wr(lig_pkg::OFF_ARBITRARY_PATTERN_HIGH, 8'h65);
    #1;
    chk_word("pattern", 24'h65_4321, arb_pattern_o);
    rchk(lig_pkg::OFF_ARBITRARY_PATTERN_MID, 8'h43, "pattern_mid");
    // 258 separate pulses so both counter bytes carry a non-zero value
    repeat (258) begin
      @(posedge clk_sys_i);
      error_inc_i <= 1'b1;
      @(posedge clk_sys_i);
      error_inc_i <= 1'b0;
    end
    rchk(lig_pkg::OFF_ERROR_COUNT_LOW, 8'h02, "count_low");
    rchk(lig_pkg::OFF_ERROR_COUNT_HIGH, 8'h01, "count_high");
    // Run the counter over its top value so the wrap event is raised
    error_inc_i <= 1'b1;
    repeat (65279) @(posedge clk_sys_i);
    error_inc_i <= 1'b0;
    rchk(lig_pkg::OFF_ERROR_COUNT_LOW, 8'h01, "count_wrapped");
    rchk(lig_pkg::OFF_EVENT_STATUS, 8'h02, "ev_wrap");
    wr(lig_pkg::OFF_EVENT_CLEAR, 8'h02);
    $display("test pattern and counter done");
  endtask : t_pattern_counter

  task automatic t_jitter();
    wr(lig_pkg::OFF_JITTER_MEAS_CONFIG, 8'h03);
    #1;
    chk_byte("jm_config", 8'h03, jitter_meas_config_o);
    pulse_jitter(12'habc, 12'h123);
    rchk(lig_pkg::OFF_JITTER_POS_PEAK_LOW, 8'hbc, "pos_low");
    rchk(lig_pkg::OFF_JITTER_POS_PEAK_HIGH, 8'h0a, "pos_high");
    rchk(lig_pkg::OFF_JITTER_NEG_PEAK_LOW, 8'h23, "neg_low");
    rchk(lig_pkg::OFF_JITTER_NEG_PEAK_HIGH, 8'h01, "neg_high");
    wr(lig_pkg::OFF_JITTER_MEAS_CONFIG, 8'h04);
    pulse_jitter(12'h456, 12'h789);
    rchk(lig_pkg::OFF_JITTER_POS_PEAK_LOW, 8'hbc, "pos_frozen");
    rchk(lig_pkg::OFF_EVENT_STATUS, 8'h04, "ev_jitter");
    wr(lig_pkg::OFF_EVENT_CLEAR, 8'h04);
    $display("test jitter done");
  endtask : t_jitter

  task automatic t_soft_reset();
    int k;
    wr(lig_pkg::OFF_EVENT_ENABLE, 8'h01);
    wr(lig_pkg::OFF_LOOPBACK_CONTROL, 8'h0f);
    #1;
    chk_byte("loopback", 8'h0f, loopback_control_o);
    wr(lig_pkg::OFF_GLOBAL_SOFT_RESET, 8'h5a);
    #1;
    chk_bit("soft_reset", 1'b1, soft_reset_o);
    // No other access until the reset has run its course
    k = 0;
    while (soft_reset_o === 1'b1) begin
      if (k > 300) begin
        errors++;
        complete_run();
      end
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    chk_word("reset_len", 24'(lig_pkg::SOFT_RESET_CYCLES), 24'(k));
    chk_byte("loop_clr", 8'h00, loopback_control_o);
    chk_word("pattern_clr", 24'h00_0000, arb_pattern_o);
    rchk(lig_pkg::OFF_ERROR_COUNT_LOW, 8'h00, "count_clr");
    rchk(lig_pkg::OFF_GLOBAL_SOFT_RESET, 8'h00, "reset_reg");
    rchk(lig_pkg::OFF_DEVICE_IDENTITY, {DEV_CODE, 4'h0}, "id_kept");
    chk_bit("irq_set", 1'b1, irq_o);
    rchk(lig_pkg::OFF_EVENT_STATUS, 8'h01, "ev_done");
    wr(lig_pkg::OFF_EVENT_ENABLE, 8'h00);
    #1;
    chk_bit("irq_masked", 1'b0, irq_o);
    wr(lig_pkg::OFF_EVENT_ENABLE, 8'h01);
    #1;
    chk_bit("irq_unmasked", 1'b1, irq_o);
    wr(lig_pkg::OFF_EVENT_CLEAR, 8'h01);
    #1;
    chk_bit("irq_clr", 1'b0, irq_o);
    rchk(lig_pkg::OFF_EVENT_STATUS, 8'h00, "ev_clr");
    $display("test soft reset done");
  endtask : t_soft_reset

  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, error_inc_i, jitter_valid_i} = 5'b10000;
    {reg_addr_i, reg_wdata_i} = '0;
    {line_status_0_i, line_status_1_i, int_flags_0_i, int_flags_1_i, int_flags_2_i} = '0;
    {jitter_pos_i, jitter_neg_i} = '0;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_identity();
    t_status();
    t_pattern_counter();
    t_jitter();
    t_soft_reset();
    complete_run();
  end
endmodule : test_line_interface_global_regs
